// ---- design/pin_cfg_pkg.sv ----
// constants and types shared by the pin function configuration block
package pin_cfg_pkg;

  // register offsets, one byte each
  localparam logic [7:0] ADDR_TX_TOGGLE_CFG  = 8'h28;
  localparam logic [7:0] ADDR_RX_TOGGLE_CFG  = 8'h29;
  localparam logic [7:0] ADDR_CARRIER_CFG    = 8'h2A;
  localparam logic [7:0] ADDR_CALL_ALERT_CFG = 8'h2B;
  localparam logic [7:0] ADDR_DTR_CFG      = 8'h2C;
  localparam logic [7:0] ADDR_DSR_CFG      = 8'h2D;
  localparam logic [7:0] ADDR_DATA_CFG     = 8'h2E;
  localparam logic [7:0] ADDR_SUSP_LEVEL   = 8'h2F;
  localparam logic [7:0] ADDR_SUSP_MODE    = 8'h31;
  localparam logic [7:0] ADDR_GPIO_LEVEL   = 8'h40;
  localparam logic [7:0] ADDR_GPIO_STATUS  = 8'h41;

  // pin indices of the configurable pads
  localparam int NUM_PINS = 6;
  localparam int PIN_TX_TOGGLE  = 0;
  localparam int PIN_RX_TOGGLE  = 1;
  localparam int PIN_CARRIER    = 2;
  localparam int PIN_CALL_ALERT = 3;
  localparam int PIN_DTR  = 4;
  localparam int PIN_DSR  = 5;

  // field positions
  localparam int PULLUP_BIT    = 7;
  localparam int PULLDOWN_BIT  = 6;
  localparam int RX_WAKE_BIT   = 5;
  localparam int TX_PP_BIT     = 0;
  localparam int USE_SUSP_BIT  = 7;
  localparam int SUSP_RX_TOGGLE_BIT = 7;
  localparam int SUSP_TX_TOGGLE_BIT = 6;
  localparam int SUSP_EXT_MSB  = 3;

  // reset values
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [5:0] LEVEL_RESET = 6'h00;
  localparam logic       RX_IDLE     = 1'b1;

  // function codes
  localparam logic [2:0] FN_GPIO_IN = 3'h0;
  localparam logic [2:0] FN_GPIO_OD = 3'h1;
  localparam logic [2:0] FN_GPIO_PP = 3'h2;
  localparam logic [2:0] FN_ALT_3   = 3'h3;
  localparam logic [2:0] FN_ALT_4   = 3'h4;

  // per pin: 3-bit field, code 3 alternate kind, code 4 alternate
  localparam logic [5:0] FN_WIDE_PINS = 6'h10;
  localparam logic [5:0] ALT3_PP_PINS = 6'h03;
  localparam logic [5:0] ALT3_OD_PINS = 6'h10;
  localparam logic [5:0] ALT4_PP_PINS = 6'h10;

  typedef enum logic [1:0] {PAD_IN, PAD_OD, PAD_PP} pad_mode_t;

endpackage

// ---- design/pad_if.sv ----
// control and drive signals between the pin decoder and one pad cell
interface pad_if;
  import pin_cfg_pkg::*;
  pad_mode_t mode;
  logic      level;
  logic      pu_req;
  logic      pd_req;
  logic      pad_out;
  logic      pad_oe;
  logic      pull_up;
  logic      pull_down;
  modport ctrl (output mode, level, pu_req, pd_req,
                input  pad_out, pad_oe, pull_up, pull_down);
  modport pad  (input  mode, level, pu_req, pd_req,
                output pad_out, pad_oe, pull_up, pull_down);
endinterface

// ---- design/pad_ctrl.sv ----
// one pad cell: driver type and pull resistor gating
module pad_ctrl
  import pin_cfg_pkg::*;
(
  // control from decoder
  pad_if.pad p
);

  always_comb begin
    p.pad_out   = 1'b0;
    p.pad_oe    = 1'b0;
    p.pull_up   = 1'b0;
    p.pull_down = 1'b0;
    unique case (p.mode)
      PAD_IN: begin
        p.pull_up   = p.pu_req;
        p.pull_down = p.pd_req & ~p.pu_req;
      end
      PAD_OD: begin
        p.pad_oe = ~p.level;
      end
      PAD_PP: begin
        p.pad_out = p.level;
        p.pad_oe  = 1'b1;
      end
      default: begin
        p.pad_oe = 1'b0;
      end
    endcase
  end

endmodule

// ---- design/wake_detect.sv ----
// receive pin activity detector for remote wakeup
module wake_detect
  import pin_cfg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // detector
  input  wire logic enable,
  input  wire logic rx_pin_in,
  output logic      wake_req
);

  typedef struct packed {
    logic prev;
    logic req;
  } wake_state_t;

  wake_state_t s;
  wake_state_t next_s;

  always_comb begin
    next_s      = s;
    next_s.prev = rx_pin_in;
    // request holds until the enable chain drops
    if (!enable) begin
      next_s.req = 1'b0;
    end else if (s.prev != rx_pin_in) begin
      next_s.req = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{prev: RX_IDLE, req: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign wake_req = s.req;

endmodule

// ---- design/uart_pin_function_config.sv ----
// pin function select and pad control for one serial channel
module uart_pin_function_config
  import pin_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  // system state
  input  wire logic                usb_suspend,
  input  wire logic                global_wake_en,
  // serial engine
  input  wire logic                tx_data,
  input  wire logic                tx_toggle,
  input  wire logic                rx_toggle,
  input  wire logic                terminal_ready,
  output logic                     data_set_ready,
  // multipurpose pads
  input  wire logic [NUM_PINS-1:0] gpio_pin_in,
  output logic      [NUM_PINS-1:0] gpio_pin_out,
  output logic      [NUM_PINS-1:0] gpio_pin_oe,
  output logic      [NUM_PINS-1:0] gpio_pull_up,
  output logic      [NUM_PINS-1:0] gpio_pull_down,
  // data pads
  output logic                     tx_pin_out,
  output logic                     tx_pin_oe,
  input  wire logic                rx_pin_in,
  output logic                     rx_pull_up,
  output logic                     rx_pull_down,
  output logic                     rx_wake_req,
  // suspend override for pins outside this block
  output logic                     ovr_active,
  output logic      [3:0]          ovr_level,
  output logic      [3:0]          ovr_open_drain
);

  typedef struct packed {
    logic [NUM_PINS-1:0][7:0] pin_cfg;
    logic [7:0]               data_cfg;
    logic [7:0]               susp_level;
    logic [7:0]               susp_mode;
    logic [NUM_PINS-1:0]      gpio_level;
    logic [7:0]               rdata;
  } state_t;

  localparam state_t STATE_RESET = '{
    pin_cfg:    {NUM_PINS{CFG_RESET}},
    data_cfg:   CFG_RESET,
    susp_level: CFG_RESET,
    susp_mode:  CFG_RESET,
    gpio_level: LEVEL_RESET,
    rdata:      CFG_RESET
  };

  state_t s;
  state_t next_s;

  logic                susp_ovr;
  logic [NUM_PINS-1:0] alt_level;

  // ---------------- register file
  always_comb begin
    next_s       = s;
    next_s.rdata = 8'h00;
    if (reg_wr) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (reg_addr == ADDR_TX_TOGGLE_CFG + 8'(i)) begin
          next_s.pin_cfg[i] = reg_wdata;
        end
      end
      unique case (reg_addr)
        ADDR_DATA_CFG:   next_s.data_cfg = reg_wdata;
        ADDR_SUSP_LEVEL: next_s.susp_level = reg_wdata;
        ADDR_SUSP_MODE:  next_s.susp_mode = reg_wdata;
        ADDR_GPIO_LEVEL: next_s.gpio_level = reg_wdata[NUM_PINS-1:0];
        default:         next_s.data_cfg = s.data_cfg;
      endcase
    end
    if (reg_rd) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (reg_addr == ADDR_TX_TOGGLE_CFG + 8'(i)) begin
          next_s.rdata = s.pin_cfg[i];
        end
      end
      unique case (reg_addr)
        ADDR_DATA_CFG:    next_s.rdata = s.data_cfg;
        ADDR_SUSP_LEVEL:  next_s.rdata = s.susp_level;
        ADDR_SUSP_MODE:   next_s.rdata = s.susp_mode;
        ADDR_GPIO_LEVEL:  next_s.rdata = {2'b00, s.gpio_level};
        ADDR_GPIO_STATUS: next_s.rdata = {2'b00, gpio_pin_in};
        default:          next_s.rdata = next_s.rdata;
      endcase
    end
  end

  // stored bytes are kept as written, except the gpio level keeps only its low six bits; reserved bits do not steer logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;

  // ---------------- multipurpose pins
  assign susp_ovr = usb_suspend & s.susp_mode[USE_SUSP_BIT];

  always_comb begin
    alt_level          = '0;
    alt_level[PIN_TX_TOGGLE] = tx_toggle;
    alt_level[PIN_RX_TOGGLE] = rx_toggle;
    alt_level[PIN_DTR] = terminal_ready;
  end

  // software also reads the handshake input pin through the gpio status register, this only exports it
  assign data_set_ready = gpio_pin_in[PIN_DSR];

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pad_if pif ();
    logic [2:0] code;

    pad_ctrl u_pad (
      .p (pif.pad)
    );

    always_comb begin
      code = FN_WIDE_PINS[i] ? s.pin_cfg[i][2:0] : {1'b0, s.pin_cfg[i][1:0]};
      pif.level  = s.gpio_level[i];
      pif.pu_req = s.pin_cfg[i][PULLUP_BIT];
      pif.pd_req = s.pin_cfg[i][PULLDOWN_BIT];
      // unlisted codes fall back to a quiet input
      unique case (code)
        FN_GPIO_IN: pif.mode = PAD_IN;
        FN_GPIO_OD: pif.mode = PAD_OD;
        FN_GPIO_PP: pif.mode = PAD_PP;
        FN_ALT_3: begin
          if (ALT3_PP_PINS[i]) begin
            pif.mode  = PAD_PP;
            pif.level = alt_level[i];
          end else if (ALT3_OD_PINS[i]) begin
            pif.mode  = PAD_OD;
            pif.level = alt_level[i];
          end else begin
            pif.mode = PAD_IN;
          end
        end
        FN_ALT_4: begin
          if (ALT4_PP_PINS[i]) begin
            pif.mode  = PAD_PP;
            pif.level = alt_level[i];
          end else begin
            pif.mode = PAD_IN;
          end
        end
        default: pif.mode = PAD_IN;
      endcase
      // toggle pins take the suspend level while the override is active
      if (susp_ovr && i == PIN_TX_TOGGLE) begin
        pif.mode  = s.susp_mode[SUSP_TX_TOGGLE_BIT] ? PAD_OD : PAD_PP;
        pif.level = s.susp_level[SUSP_TX_TOGGLE_BIT];
      end
      if (susp_ovr && i == PIN_RX_TOGGLE) begin
        pif.mode  = s.susp_mode[SUSP_RX_TOGGLE_BIT] ? PAD_OD : PAD_PP;
        pif.level = s.susp_level[SUSP_RX_TOGGLE_BIT];
      end
    end

    assign gpio_pin_out[i]   = pif.pad_out;
    assign gpio_pin_oe[i]    = pif.pad_oe;
    assign gpio_pull_up[i]   = pif.pull_up;
    assign gpio_pull_down[i] = pif.pull_down;
  end

  // enable, clear-to-send, request-to-send and clock pins live elsewhere
  assign ovr_active     = susp_ovr;
  assign ovr_level      = s.susp_level[SUSP_EXT_MSB:0];
  assign ovr_open_drain = s.susp_mode[SUSP_EXT_MSB:0];

  // ---------------- data pins, never touched by the suspend override
  always_comb begin
    if (s.data_cfg[TX_PP_BIT]) begin
      tx_pin_out = tx_data;
      tx_pin_oe  = 1'b1;
    end else begin
      tx_pin_out = 1'b0;
      tx_pin_oe  = ~tx_data;
    end
  end

  assign rx_pull_up   = s.data_cfg[PULLUP_BIT];
  assign rx_pull_down = s.data_cfg[PULLDOWN_BIT] & ~s.data_cfg[PULLUP_BIT];

  wake_detect u_wake (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .enable    (s.data_cfg[RX_WAKE_BIT] & global_wake_en & usb_suspend),
    .rx_pin_in (rx_pin_in),
    .wake_req  (rx_wake_req)
  );

endmodule

// ---- tb/uart_pin_function_config_chk.sv ----
// port checks for the pin configuration block
module uart_pin_function_config_chk
  import pin_cfg_pkg::*;
(
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                rst_b,
  // register read and system state
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                usb_suspend,
  input wire logic                global_wake_en,
  // pads
  input wire logic [NUM_PINS-1:0] gpio_pin_oe,
  input wire logic [NUM_PINS-1:0] gpio_pull_up,
  input wire logic [NUM_PINS-1:0] gpio_pull_down,
  input wire logic                tx_data,
  input wire logic                tx_pin_oe,
  input wire logic                rx_pull_up,
  input wire logic                rx_pull_down,
  input wire logic                rx_wake_req,
  input wire logic                ovr_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // enable must stay low long enough for the registered clear
  sequence wake_cut;
    !global_wake_en [*3];
  endsequence
  sequence wake_set;
    !rx_wake_req ##1 rx_wake_req;
  endsequence
  AST_PULL_EXCL: assert property ((gpio_pull_up & gpio_pull_down) == '0)
    else $error("pad pull-up and pull-down on together");
  AST_PULL_IN: assert property (((gpio_pull_up | gpio_pull_down) & gpio_pin_oe) == '0)
    else $error("pull on a driven pad");
  AST_RX_PULL: assert property (!(rx_pull_up && rx_pull_down))
    else $error("receive pin pulls both on");
  AST_TX_LOW: assert property (!tx_data |-> tx_pin_oe)
    else $error("transmit low not driven");
  AST_OVR_SUSP: assert property (ovr_active |-> usb_suspend)
    else $error("override outside suspend");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_WAKE_CLR: assert property (wake_cut |-> !rx_wake_req)
    else $error("wake held without global enable");
  AST_WAKE_SET: assert property (wake_set |-> $past(global_wake_en) && $past(usb_suspend))
    else $error("wake raised while not enabled");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    !rst_b |-> gpio_pin_oe == '0 && !ovr_active && !rx_wake_req)
    else $error("pads active in reset");
endmodule

bind uart_pin_function_config uart_pin_function_config_chk i_chk (
  .sys_clk, .rst_b, .reg_rd, .reg_rdata, .usb_suspend, .global_wake_en, .gpio_pin_oe,
  .gpio_pull_up, .gpio_pull_down, .tx_data, .tx_pin_oe, .rx_pull_up, .rx_pull_down,
  .rx_wake_req, .ovr_active
);

// ---- tb/pad_board.sv ----
// board side of the multipurpose pads: external drivers and floating lines
module pad_board
  import pin_cfg_pkg::*;
(
  // clock
  input  wire logic                sys_clk,
  // pads from the block
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe,
  input  wire logic [NUM_PINS-1:0] pull_up,
  input  wire logic [NUM_PINS-1:0] pull_down,
  // external drivers
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_val,
  // resolved pad level
  output logic      [NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // an undriven pad must not look stable, so it flips every cycle
  logic [NUM_PINS-1:0] drift = '0;
  always @(posedge sys_clk) drift <= ~pin_in;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up[i]) pin_in[i] = 1'b1;
      else if (pull_down[i]) pin_in[i] = 1'b0;
      else pin_in[i] = drift[i];
    end
  end
endmodule

// ---- tb/uart_pin_function_config_tb.sv ----
// self-checking bench for the pin function configuration block
module uart_pin_function_config_tb
  import pin_cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic                sys_clk = 1'b0;
  logic                rst_b = 1'b1;
  logic [7:0]          reg_addr = 8'h00;
  logic [7:0]          reg_wdata = 8'h00;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic                usb_suspend = 1'b0;
  logic                global_wake_en = 1'b0;
  logic                tx_data = 1'b0;
  logic                tx_toggle = 1'b0;
  logic                rx_toggle = 1'b0;
  logic                terminal_ready = 1'b0;
  logic                rx_pin_in = 1'b1;
  logic [NUM_PINS-1:0] ext_en = '0;
  logic [NUM_PINS-1:0] ext_val = '0;
  logic [NUM_PINS-1:0] gpio_pin_in, gpio_pin_out, gpio_pin_oe, gpio_pull_up, gpio_pull_down;
  logic [7:0]          reg_rdata;
  logic [3:0]          ovr_level, ovr_open_drain;
  logic                data_set_ready, tx_pin_out, tx_pin_oe, rx_pull_up, rx_pull_down;
  logic                rx_wake_req, ovr_active;
  int                  num_errors = 0;
  int                  checks_done = 0;

  uart_pin_function_config i_dut (
    .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .usb_suspend,
    .global_wake_en, .tx_data, .tx_toggle, .rx_toggle, .terminal_ready, .data_set_ready,
    .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe, .gpio_pull_up, .gpio_pull_down, .tx_pin_out,
    .tx_pin_oe, .rx_pin_in, .rx_pull_up, .rx_pull_down, .rx_wake_req, .ovr_active,
    .ovr_level, .ovr_open_drain
  );
  pad_board i_board (
    .sys_clk, .pin_out(gpio_pin_out), .pin_oe(gpio_pin_oe), .pull_up(gpio_pull_up),
    .pull_down(gpio_pull_down), .ext_en, .ext_val, .pin_in(gpio_pin_in)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // idle cycle after the strobe keeps strobe updates one per time step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk("rdata", e, reg_rdata);
  endtask

  // {input mode, oe, out} for pin p, code c, gpio level l, alternate level a
  function automatic logic [2:0] pad_exp(int p, int c, logic l, logic a);
    case (c)
      1: return {1'b0, ~l, 1'b0};
      2: return {2'b01, l};
      3: if (p < 2) return {2'b01, a};
         else if (p == PIN_DTR) return {1'b0, ~a, 1'b0};
      4: if (p == PIN_DTR) return {2'b01, a};
      default: ;
    endcase
    return 3'b100;
  endfunction

  task automatic reset_map();
    for (int a = 0; a < 7; a++) rd(ADDR_TX_TOGGLE_CFG + 8'(a), 8'h00);
    chk("oe rst", 8'h00, {2'b00, gpio_pin_oe});
    chk("tx od rst", 8'h01, {7'h00, tx_pin_oe});
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    wr(ADDR_SUSP_LEVEL, 8'hCF);
    rd(ADDR_SUSP_LEVEL, 8'hCF);
  endtask

  // dtr alternate codes run with every other pin left at code 0, an input
  task automatic fn_table();
    logic [2:0] e;
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int c = 0; c < ((p == PIN_DTR) ? 8 : 4); c++) begin
        for (int l = 0; l < 2; l++) begin
          e = pad_exp(p, c, l[0], ~l[0]);
          tx_toggle <= ~l[0];
          rx_toggle <= ~l[0];
          terminal_ready <= ~l[0];
          wr(ADDR_GPIO_LEVEL, l[0] ? 8'h3F : 8'h00);
          wr(ADDR_TX_TOGGLE_CFG + 8'(p), (l[0] ? 8'hC0 : 8'h40) | 8'(c));
          chk("pad oe", {7'h00, e[1]}, {7'h00, gpio_pin_oe[p]});
          if (e[1]) chk("pad out", {7'h00, e[0]}, {7'h00, gpio_pin_out[p]});
          chk("pull up", {7'h00, e[2] & l[0]}, {7'h00, gpio_pull_up[p]});
          chk("pull down", {7'h00, e[2] & ~l[0]}, {7'h00, gpio_pull_down[p]});
        end
      end
      wr(ADDR_TX_TOGGLE_CFG + 8'(p), 8'h00);
    end
  endtask

  task automatic data_pins();
    tx_data <= 1'b1;
    wr(ADDR_DATA_CFG, 8'hC0);
    chk("tx oe od", 8'h00, {7'h00, tx_pin_oe});
    chk("rx pu", 8'h01, {7'h00, rx_pull_up});
    chk("rx pd", 8'h00, {7'h00, rx_pull_down});
    wr(ADDR_DATA_CFG, 8'h41);
    chk("tx oe pp", 8'h01, {7'h00, tx_pin_oe & tx_pin_out});
    chk("rx pd on", 8'h01, {6'h00, rx_pull_up, rx_pull_down});
    rd(ADDR_DATA_CFG, 8'h41);
    wr(ADDR_DSR_CFG, 8'h80);
    chk("dsr pulled", 8'h01, {7'h00, data_set_ready});
    ext_en <= 6'h3F;
    ext_val <= 6'h1A;
    @(posedge sys_clk);
    chk("dsr driven", 8'h00, {7'h00, data_set_ready});
    rd(ADDR_GPIO_STATUS, 8'h1A);
    ext_en <= '0;
    wr(ADDR_DSR_CFG, 8'h00);
  endtask

  task automatic suspend();
    tx_data <= 1'b0;
    tx_toggle <= 1'b0;
    usb_suspend <= 1'b1;
    wr(ADDR_TX_TOGGLE_CFG, 8'h03);
    wr(ADDR_SUSP_LEVEL, 8'h4A);
    wr(ADDR_SUSP_MODE, 8'h05);
    chk("ovr off", 8'h00, {7'h00, ovr_active});
    chk("toggle", 8'h02, {6'h00, gpio_pin_oe[0], gpio_pin_out[0]});
    wr(ADDR_SUSP_MODE, 8'h85);
    chk("ovr on", 8'h01, {7'h00, ovr_active});
    chk("ovr lvl", 8'hA5, {ovr_level, ovr_open_drain});
    chk("toggle pins", 8'h0D, {4'h0, gpio_pin_oe[1:0], gpio_pin_out[1:0]});
    chk("tx kept", 8'h02, {6'h00, tx_pin_oe, tx_pin_out});
    usb_suspend <= 1'b0;
    @(posedge sys_clk);
    chk("ovr end", 8'h00, {7'h00, ovr_active});
  endtask

  task automatic wake();
    int n;
    usb_suspend <= 1'b1;
    wr(ADDR_DATA_CFG, 8'h20);
    rx_pin_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("wake no global", 8'h00, {7'h00, rx_wake_req});
    global_wake_en <= 1'b1;
    @(posedge sys_clk);
    rx_pin_in <= 1'b1;
    n = 0;
    while (rx_wake_req !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wake", 8'h01, {7'h00, rx_wake_req});
    if (n == 8) tally_and_finish();
    global_wake_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("wake clr", 8'h00, {7'h00, rx_wake_req});
    usb_suspend <= 1'b0;
  endtask

  initial begin
    // a real falling edge, so the asynchronous reset acts before the first clock
    rst_b <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    reset_map();
    fn_table();
    data_pins();
    suspend();
    wake();
    rst_b <= 1'b0;
    @(posedge sys_clk);
    chk("oe mid rst", 8'h00, {2'b00, gpio_pin_oe});
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_SUSP_MODE, 8'h00);
    tally_and_finish();
  end
endmodule
